// [design/latched_config_snapshot_regs.sv]
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
module latched_config_snapshot_regs
  import snapshot_pkg::*;
#(
  parameter int VALID_WAIT = VALID_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic pin1_i,
  input wire logic pin2_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  output logic snapshot_valid_o,
  output logic force_slow_o,
  output logic [3:0] chan_active_o,
  output logic [2:0] sample_mode_o,
  output logic skip_inhibit_o
);

  logic [15:0] prog_ctrl_q, prog_ctrl_d;
  logic [15:0] prog_range_q, prog_range_d;
  logic [15:0] act_ctrl_q, act_ctrl_d;
  logic [15:0] act_range_q, act_range_d;
  logic [15:0] lat_ctrl_q, lat_ctrl_d;
  logic [15:0] lat_range_q, lat_range_d;
  logic skip_inh_q, skip_inh_d;
  logic seen_q, seen_d;
  valid_state_t vst_q, vst_d;
  logic [19:0] vcnt_q, vcnt_d;
  logic valid_q, valid_d;
  logic [31:0] dat_q, dat_d;
  logic ack_q, ack_d;
  logic err_q, err_d;
  logic slow_q, slow_d;
  logic [3:0] chact_q, chact_d;
  sample_mode_t mode_q, mode_d;
  logic [1:0] p1_meta_q, p1_sync_q;
  logic [15:0] ctrl_reset;
  logic req;
  logic [7:0] idx;
  logic upd;
  logic sel_lo;

  // reset default follows how many channels the part carries
  always_comb
  begin
    unique case (NUM_CHANNELS)
      3'h1: ctrl_reset = CTRL_RESET_1CH;
      3'h2: ctrl_reset = CTRL_RESET_2CH;
      3'h3: ctrl_reset = CTRL_RESET_3CH;
      default: ctrl_reset = CTRL_RESET_4CH;
    endcase
  end

  // pins are asynchronous: two flops before any logic
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p1_meta_q <= 2'h0;
      p1_sync_q <= 2'h0;
    end
    else
    begin
      p1_meta_q <= {pin2_i, pin1_i};
      p1_sync_q <= p1_meta_q;
    end
  end

  // new request only when no answer is out, so each access acks once
  assign req = cyc_i & stb_i & ~ack_q & ~err_q;
  assign idx = adr_i[9:2];
  assign sel_lo = sel_i[0] & sel_i[1];
  assign upd = req & we_i & (idx == CMD_IDX) & sel_i[0]
    & dat_i[CMD_UPDATE_BIT];

  // register file and update-command transfer
  always_comb
  begin
    prog_ctrl_d = prog_ctrl_q;
    prog_range_d = prog_range_q;
    act_ctrl_d = act_ctrl_q;
    act_range_d = act_range_q;
    lat_ctrl_d = lat_ctrl_q;
    lat_range_d = lat_range_q;
    skip_inh_d = skip_inh_q;
    seen_d = seen_q;
    if (req & we_i & sel_lo)
    begin
      // snapshot and active indices are not writable here
      if (idx == PROG_CTRL_IDX)
        prog_ctrl_d = dat_i[15:0] & CTRL_IMPL_MASK;
      if (idx == PROG_RANGE_IDX)
        prog_range_d = dat_i[15:0];
    end
    if (req & we_i & sel_i[0] & (idx == CMD_IDX))
      skip_inh_d = dat_i[CMD_SKIP_INH_BIT];
    if (upd)
    begin
      lat_ctrl_d = act_ctrl_q;
      lat_range_d = act_range_q;
      act_ctrl_d = prog_ctrl_q;
      act_range_d = prog_range_q;
      seen_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prog_ctrl_q <= CTRL_RESET_4CH;
      prog_range_q <= RANGE_RESET;
      act_ctrl_q <= CTRL_RESET_4CH;
      act_range_q <= RANGE_RESET;
      lat_ctrl_q <= CTRL_RESET_4CH;
      lat_range_q <= RANGE_RESET;
      skip_inh_q <= 1'b0;
      seen_q <= 1'b0;
    end
    else if (!seen_q && !upd && lat_ctrl_q != ctrl_reset)
    begin
      // load channel-count default once after release
      prog_ctrl_q <= ctrl_reset;
      act_ctrl_q <= ctrl_reset;
      lat_ctrl_q <= ctrl_reset;
      prog_range_q <= prog_range_d;
      skip_inh_q <= skip_inh_d;
    end
    else
    begin
      prog_ctrl_q <= prog_ctrl_d;
      prog_range_q <= prog_range_d;
      act_ctrl_q <= act_ctrl_d;
      act_range_q <= act_range_d;
      lat_ctrl_q <= lat_ctrl_d;
      lat_range_q <= lat_range_d;
      skip_inh_q <= skip_inh_d;
      seen_q <= seen_d;
    end
  end

  // validity timer: snapshot trusted 1 ms after each update
  always_comb
  begin
    vst_d = vst_q;
    vcnt_d = vcnt_q;
    unique case (vst_q)
      ST_NONE:
      begin
        if (upd)
        begin
          vst_d = ST_WAIT;
          vcnt_d = 20'(VALID_WAIT - 1);
        end
      end
      ST_WAIT:
      begin
        if (upd)
          vcnt_d = 20'(VALID_WAIT - 1); // restart on repeat update
        else if (vcnt_q == 20'h0)
          vst_d = ST_VALID;
        else
          vcnt_d = vcnt_q - 20'h1;
      end
      ST_VALID:
      begin
        if (upd)
        begin
          vst_d = ST_WAIT;
          vcnt_d = 20'(VALID_WAIT - 1);
        end
      end
    endcase
    // flag registered from the next state, so it keeps the state's timing
    valid_d = (vst_d == ST_VALID);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vst_q <= ST_NONE;
      vcnt_q <= 20'h0;
      valid_q <= 1'b0;
    end
    else
    begin
      vst_q <= vst_d;
      vcnt_q <= vcnt_d;
      valid_q <= valid_d;
    end
  end

  // decode of the active settings into conversion controls
  always_comb
  begin
    logic [3:0] m;
    logic [1:0] f1;
    logic [1:0] f2;
    m = act_ctrl_q[MODE_LSB +: 4];
    f1 = act_ctrl_q[PIN1_LSB +: 2];
    f2 = act_ctrl_q[PIN2_LSB +: 2];
    // one mode only, by construction of the encoding
    if (m <= MODE_ACC_MAX)
      mode_d = SM_ACCUM;
    else if (m <= MODE_CONT_MAX)
      mode_d = SM_CONT;
    else if (m == MODE_SINGLE)
      mode_d = SM_SINGLE;
    else if (m == MODE_SINGLE8)
      mode_d = SM_SINGLE8;
    else if (m == MODE_FAST)
      mode_d = SM_FAST;
    else if (m == MODE_BURST)
      mode_d = SM_BURST;
    else if (m == MODE_SLEEP)
      mode_d = SM_SLEEP;
    else
      mode_d = SM_RESV;
    // either pin as rate-reduction input, driven high
    slow_d = ((f1 == PIN_SLOW) & p1_sync_q[0])
      | ((f2 == PIN_SLOW) & p1_sync_q[1]);
    chact_d = ~act_ctrl_q[CHOFF_LSB +: 4];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= SM_ACCUM;
      slow_q <= 1'b0;
      chact_q <= 4'hf;
    end
    else
    begin
      mode_q <= mode_d;
      slow_q <= slow_d;
      chact_q <= chact_d;
    end
  end

  // wishbone answer: ack one cycle after the request is seen
  always_comb
  begin
    dat_d = 32'h0;
    ack_d = 1'b0;
    err_d = 1'b0;
    if (req)
    begin
      ack_d = 1'b1;
      unique case (idx)
        ACTIVE_CTRL_IDX: dat_d = {16'h0, act_ctrl_q};
        ACTIVE_RANGE_IDX: dat_d = {16'h0, act_range_q};
        LAT_CTRL_IDX: dat_d = {16'h0, lat_ctrl_q & CTRL_IMPL_MASK};
        LAT_RANGE_IDX: dat_d = {16'h0, lat_range_q};
        PROG_CTRL_IDX: dat_d = {16'h0, prog_ctrl_q};
        PROG_RANGE_IDX: dat_d = {16'h0, prog_range_q};
        CMD_IDX: dat_d = {30'h0, skip_inh_q, 1'b0};
        STATUS_IDX:
        begin
          dat_d[ST_VALID_BIT] = (vst_q == ST_VALID);
          dat_d[ST_SEEN_BIT] = seen_q;
          dat_d[ST_FORCE_SLOW_BIT] = slow_q;
          dat_d[ST_SLEEP_BIT] = (mode_q == SM_SLEEP);
          dat_d[ST_RESV_BIT] = (mode_q == SM_RESV);
          dat_d[ST_SKIP_BIT] = ~skip_inh_q;
        end
        default:
        begin
          ack_d = 1'b0;
          err_d = 1'b1; // unmapped address
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_q <= 32'h0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      dat_q <= dat_d;
      ack_q <= ack_d;
      err_q <= err_d;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign err_o = err_q;
  assign force_slow_o = slow_q;
  assign chan_active_o = chact_q;
  assign sample_mode_o = mode_q;
  // snapshot trusted only after first update and its settle time
  assign snapshot_valid_o = valid_q;
  assign skip_inhibit_o = skip_inh_q;

endmodule // latched_config_snapshot_regs

// [design/snapshot_pkg.sv]
package snapshot_pkg;
  // word addresses: printed offsets are not multiples of four
  localparam logic [7:0] ACTIVE_CTRL_IDX = 8'h21;
  localparam logic [7:0] ACTIVE_RANGE_IDX = 8'h22;
  localparam logic [7:0] LAT_CTRL_IDX = 8'h23;
  localparam logic [7:0] LAT_RANGE_IDX = 8'h24;
  localparam logic [7:0] PROG_CTRL_IDX = 8'h30;
  localparam logic [7:0] PROG_RANGE_IDX = 8'h31;
  localparam logic [7:0] CMD_IDX = 8'h32;
  localparam logic [7:0] STATUS_IDX = 8'h33;
  // command register bits
  localparam int CMD_UPDATE_BIT = 0;
  localparam int CMD_SKIP_INH_BIT = 1;
  // status register bits
  localparam int ST_VALID_BIT = 0;
  localparam int ST_SEEN_BIT = 1;
  localparam int ST_FORCE_SLOW_BIT = 2;
  localparam int ST_SLEEP_BIT = 3;
  localparam int ST_RESV_BIT = 4;
  localparam int ST_SKIP_BIT = 5;
  // control field positions
  localparam int MODE_LSB = 12;
  localparam int PIN2_LSB = 10;
  localparam int PIN1_LSB = 8;
  localparam int CHOFF_LSB = 4;
  localparam logic [15:0] CTRL_IMPL_MASK = 16'hfff0;
  // reset values
  localparam logic [15:0] CTRL_RESET_4CH = 16'h0700;
  localparam logic [15:0] CTRL_RESET_3CH = 16'h0710;
  localparam logic [15:0] CTRL_RESET_2CH = 16'h0730;
  localparam logic [15:0] CTRL_RESET_1CH = 16'h0770;
  localparam logic [15:0] RANGE_RESET = 16'h0000;
  localparam logic [2:0] NUM_CHANNELS = 3'h4;
  // sampling mode codes
  localparam logic [3:0] MODE_ACC_MAX = 4'h3;
  localparam logic [3:0] MODE_CONT_MAX = 4'h7;
  localparam logic [3:0] MODE_SINGLE = 4'h8;
  localparam logic [3:0] MODE_SINGLE8 = 4'h9;
  localparam logic [3:0] MODE_FAST = 4'ha;
  localparam logic [3:0] MODE_BURST = 4'hb;
  localparam logic [3:0] MODE_SLEEP = 4'hf;
  localparam logic [3:0] MODE_RESV_MIN = 4'hc;
  // pin function codes
  localparam logic [1:0] PIN_ALERT = 2'h0;
  localparam logic [1:0] PIN_GPIN = 2'h1;
  localparam logic [1:0] PIN_GPOUT = 2'h2;
  localparam logic [1:0] PIN_SLOW = 2'h3;
  // range codes
  localparam logic [1:0] RANGE_RESV = 2'h3;
  // validity delay
  localparam int CLK_HZ = 10_000_000;
  localparam int VALID_DELAY_US = 1000;
  localparam int VALID_CYCLES = (CLK_HZ / 1_000_000) * VALID_DELAY_US;
  typedef enum logic [1:0] {ST_NONE, ST_WAIT, ST_VALID} valid_state_t;
  typedef enum logic [2:0] {
    SM_ACCUM, SM_CONT, SM_SINGLE, SM_SINGLE8, SM_FAST, SM_BURST,
    SM_RESV, SM_SLEEP
  } sample_mode_t;
endpackage

// [sim/snapshot_assertions.sv]
`timescale 1ns/1ns
module snapshot_assertions
  import snapshot_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic pin1_i,
  input wire logic pin2_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic snapshot_valid_o,
  input wire logic force_slow_o,
  input wire logic [2:0] sample_mode_o
);
  logic take, upd, mapped, seen_q, seen_d;
  logic [7:0] idx_q, idx_d, age_q, age_d;
  // request decode, same qualifiers as the slave uses to take a request
  assign take = cyc_i && stb_i && !ack_o && !err_o;
  assign upd = take && we_i && sel_i[0] && dat_i[CMD_UPDATE_BIT]
    && adr_i[9:2] == CMD_IDX;
  assign mapped = adr_i[9:2] inside {[8'h21:8'h24], [8'h30:8'h33]};
  // age saturates so a quiet bus never wraps back into the window
  always_comb
  begin
    idx_d = take ? adr_i[9:2] : idx_q;
    age_d = upd ? 8'h00 : (age_q == 8'hff ? age_q : age_q + 8'h01);
    seen_d = seen_q || upd;
  end
  always_ff @(posedge clk_i)
  begin
    idx_q <= rst_i ? 8'h00 : idx_d;
    age_q <= rst_i ? 8'hff : age_d;
    seen_q <= rst_i ? 1'b0 : seen_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_mapped: assert property (take && mapped
    |=> ack_o && !err_o)
    else $error("mapped access not acked");
  chk_err_unmapped: assert property (take && !mapped
    |=> err_o && !ack_o)
    else $error("unmapped access not refused");
  chk_lat_low: assert property (ack_o && idx_q == LAT_CTRL_IDX
    |-> dat_o[3:0] == 4'h0 && dat_o[31:16] == 16'h0)
    else $error("unimplemented bits not zero");
  chk_valid_drop: assert property (upd |=> !snapshot_valid_o [*8])
    else $error("valid too early after update");
  chk_valid_rise: assert property (upd
    |-> ##[16:24] snapshot_valid_o)
    else $error("valid late after update");
  chk_first_update: assert property (!seen_q |-> !snapshot_valid_o)
    else $error("valid before first update");
  chk_slow_idle: assert property ((!pin1_i && !pin2_i) [*5]
    |-> !force_slow_o)
    else $error("slow forced with pins low");
  chk_mode_update: assert property ($changed(sample_mode_o)
    |-> age_q < 8'h04)
    else $error("mode changed without update");
endmodule // snapshot_assertions
bind latched_config_snapshot_regs snapshot_assertions chk_u (.clk_i, .rst_i,
  .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .pin1_i, .pin2_i, .dat_o,
  .ack_o,
  .err_o, .snapshot_valid_o, .force_slow_o, .sample_mode_o);

// [sim/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import snapshot_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, pin1_i, pin2_i, ack_o, err_o;
  logic snapshot_valid_o, force_slow_o, skip_inhibit_o;
  logic [9:0] adr_i;
  logic [3:0] sel_i, chan_active_o;
  logic [31:0] dat_i, dat_o;
  logic [2:0] sample_mode_o;
  int n_fail = 0;
  int cmp_count = 0;
  latched_config_snapshot_regs #(.VALID_WAIT(20)) dut_u (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .pin1_i, .pin2_i, .dat_o,
    .ack_o, .err_o, .snapshot_valid_o, .force_slow_o, .chan_active_o,
    .sample_mode_o, .skip_inhibit_o);
  wb_host host_u (.clk_i, .ack_i(ack_o), .err_i(err_o), .dat_i(dat_o),
    .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i),
    .dat_o(dat_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    logic e;
    host_u.xfer(1'b0, a, 16'h0, d, e);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    logic [31:0] d;
    logic e;
    host_u.xfer(1'b1, a, v, d, e);
  endtask
  function automatic logic [2:0] mode_of(input logic [3:0] m);
    if (m <= MODE_ACC_MAX) return 3'h0;
    if (m <= MODE_CONT_MAX) return 3'h1;
    if (m >= MODE_RESV_MIN) return m == MODE_SLEEP ? 3'h7 : 3'h6;
    return 3'(m - 4'h6);
  endfunction
  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // defaults after reset; pin one defaults to the slow function
  task automatic t_reset;
    logic [31:0] d;
    chk(snapshot_valid_o, 1'b0);
    chk(chan_active_o, 4'hf);
    chk(sample_mode_o, 3'h0);
    rd_reg(LAT_CTRL_IDX, d);
    chk(d, 32'h0700);
    rd_reg(LAT_RANGE_IDX, d);
    chk(d, 32'h0);
    pin1_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(force_slow_o, 1'b1);
    pin1_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk(force_slow_o, 1'b0);
    $display("test reset done");
  endtask
  // writes to snapshots are ignored; unmapped index refused
  task automatic t_readonly;
    logic [31:0] d;
    logic e;
    wr_reg(LAT_CTRL_IDX, 16'hffff);
    wr_reg(LAT_RANGE_IDX, 16'hffff);
    rd_reg(LAT_CTRL_IDX, d);
    chk(d, 32'h0700);
    rd_reg(LAT_RANGE_IDX, d);
    chk(d, 32'h0);
    host_u.xfer(1'b0, 8'h40, 16'h0, d, e);
    chk(e, 1'b1);
    chk(snapshot_valid_o, 1'b0);
    $display("test readonly done");
  endtask
  // every mode code once; low nibble written as ones to prove it drops
  task automatic t_update;
    logic [15:0] c, r, pc, pr;
    logic s;
    logic [31:0] d;
    int n;
    pc = CTRL_RESET_4CH;
    pr = RANGE_RESET;
    for (int i = 0; i < 16; i++)
    begin
      c = {i[3:0], i[1:0], i[3:2], i[3:0], 4'hf};
      r = {4{i[3:0]}};
      pin1_i <= i[0];
      pin2_i <= i[1];
      wr_reg(PROG_CTRL_IDX, c);
      wr_reg(PROG_RANGE_IDX, r);
      wr_reg(CMD_IDX, {14'h0, i[0], 1'b1});
      chk(snapshot_valid_o, 1'b0);
      n = 0;
      // host holds off reading until the snapshot is valid
      while (!snapshot_valid_o && n < 100)
      begin
        @(posedge clk_i);
        n++;
      end
      chk(n > 14 && n < 24, 1'b1);
      rd_reg(LAT_CTRL_IDX, d);
      chk(d, pc);
      rd_reg(LAT_RANGE_IDX, d);
      chk(d, pr);
      rd_reg(ACTIVE_CTRL_IDX, d);
      chk(d, c & CTRL_IMPL_MASK);
      chk(sample_mode_o, mode_of(i[3:0]));
      chk(chan_active_o, 4'(~i[3:0]));
      chk(skip_inhibit_o, i[0]);
      s = (i[0] && i[3:2] == 2'h3) || (i[1] && i[1:0] == 2'h3);
      chk(force_slow_o, s);
      // status: skip enabled, reserved, sleep, slow, seen, valid
      rd_reg(STATUS_IDX, d);
      chk(d, {26'h0, ~i[0], i[3:2] == 2'h3 && i[1:0] != 2'h3,
        i[3:0] == 4'hf, s, 2'h3});
      rd_reg(CMD_IDX, d);
      chk(d, {30'h0, i[0], 1'b0});
      pc = c & CTRL_IMPL_MASK;
      pr = r;
    end
    $display("test update done");
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial
  begin
    rst_i <= 1'b1;
    pin1_i <= 1'b0;
    pin2_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset;
    t_readonly;
    t_update;
    report_and_stop;
  end
  // the whole run needs about 800 cycles
  initial
  begin
    repeat (6000) @(posedge clk_i);
    n_fail++;
    report_and_stop;
  end
endmodule // testbench

// [sim/wb_host.sv]
`timescale 1ns/1ns
module wb_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [9:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // bus idle from time zero
  initial
  begin
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= 10'h0;
    sel_o <= 4'h0;
    dat_o <= 32'h0;
  end
  // one classic cycle; request held until ack or err is sampled high
  task automatic xfer(input logic w, input logic [7:0] idx,
    input logic [15:0] wd, output logic [31:0] rd, output logic e);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'hf;
    dat_o <= {16'h0, wd};
    // no cycle limit here: a hung slave is caught by the bench watchdog
    do
    begin
      @(posedge clk_i);
    end
    while (!(ack_i || err_i));
    rd = dat_i;
    e = err_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule // wb_host
